// [hdl/scde_pkg.sv]
package scde_pkg;

  // channel count and data path widths
  localparam int          NCH      = 6;
  localparam int          AW       = 16;
  localparam int          DW       = 16;
  localparam int          NEV      = 7;
  // one reload set for all channels; 1'b1 gives each channel its own
  localparam bit          PER_CH_RELOAD = 1'b0;
  // write addresses below this decode as on-chip, everything else external; reads are always flagged on-chip
  localparam logic [15:0] ONCHIP_TOP    = 16'h8000;

  // register pages: adr[7:5] selects the page, adr[4:2] the register
  localparam logic [2:0]  PAGE_GLOBAL = 3'h6;
  localparam logic [2:0]  PAGE_CTRL   = 3'h7;
  localparam logic [2:0]  REG_SRC     = 3'h0;
  localparam logic [2:0]  REG_DST     = 3'h1;
  localparam logic [2:0]  REG_ECNT    = 3'h2;
  localparam logic [2:0]  REG_FCNT    = 3'h3;
  localparam logic [2:0]  REG_MODE    = 3'h4;
  localparam logic [2:0]  REG_ESIZE   = 3'h5;
  localparam logic [2:0]  G_SRC       = 3'h0;
  localparam logic [2:0]  G_DST       = 3'h1;
  localparam logic [2:0]  G_CNT       = 3'h2;
  localparam logic [2:0]  G_FRM       = 3'h3;
  localparam logic [2:0]  G_ESTEP     = 3'h4;
  localparam logic [2:0]  G_FSTEP     = 3'h5;
  localparam logic [2:0]  C_ENABLE    = 3'h0;
  localparam logic [2:0]  C_RSEL      = 3'h1;
  localparam logic [2:0]  C_STATUS    = 3'h2;

  // values after reset
  localparam logic [15:0] MODE_RST    = 16'h0000;
  localparam logic [7:0]  FRAME_RST   = 8'h00;
  localparam logic [15:0] WORD_RST    = 16'h0000;

  // address adjust codes
  localparam logic [1:0]  ADJ_HOLD = 2'h0;
  localparam logic [1:0]  ADJ_INC  = 2'h1;
  localparam logic [1:0]  ADJ_DEC  = 2'h2;
  localparam logic [1:0]  ADJ_IDX  = 2'h3;

  // channel mode control word
  typedef struct packed {
    logic [3:0] rsvd;
    logic [1:0] dst_adj;
    logic [1:0] src_adj;
    logic       dword;
    logic       interrupt_mode_bit;
    logic       interrupt_enable_bit;
    logic       auto_reload_flag;
    logic       hipri;
    logic [2:0] sync;
  } scde_mode_s;

  // memory request toward on-chip and external memory
  typedef struct packed {
    logic          rd;
    logic          wr;
    logic          ext;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdat;
  } scde_mem_s;

  // five states per 16-bit transfer after the grant
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD, ST_WAIT, ST_CAP, ST_WR, ST_UPD
  } scde_state_e;

endpackage : scde_pkg

// [hdl/scde_engine.sv]
// Our own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module scde_engine (
  input  wire logic                     CLK,
  input  wire logic                     ARST_N,
  input  wire logic                     WB_CYC_I,
  input  wire logic                     WB_STB_I,
  input  wire logic                     WB_WE_I,
  input  wire logic [7:0]               WB_ADR_I,
  input  wire logic [3:0]               WB_SEL_I,
  input  wire logic [31:0]              WB_DAT_I,
  output logic      [31:0]              WB_DAT_O,
  output logic                          WB_ACK_O,
  input  wire logic [scde_pkg::NEV-1:0] EVENT,
  input  wire logic [15:0]              MEM_RDAT,
  output scde_pkg::scde_mem_s           MEM_O,
  input  wire logic                     CPU_REQ,
  output logic                          CPU_GNT,
  output logic [scde_pkg::NCH-1:0]      IRQ
);

  localparam int N = scde_pkg::NCH;

  // channel context
  logic [15:0]         source_pointer      [N];
  logic [15:0]         destination_pointer [N];
  logic [15:0]         element_counter     [N];
  logic [15:0]         element_size        [N]; // frame length, reused
  logic [7:0]          frame_counter       [N];
  scde_pkg::scde_mode_s channel_mode_control [N];
  logic [N-1:0]        enable;
  logic [N-1:0]        pend;
  // reload sets: only index 0 is used in the shared variant
  logic [15:0]         global_source_reload      [N];
  logic [15:0]         global_destination_reload [N];
  logic [15:0]         global_count_reload       [N];
  logic [7:0]          global_frame_reload       [N];
  logic [15:0]         element_step_0;
  logic [15:0]         frame_step_0;
  logic [2:0]          rsel;            // reload set seen by the bus
  // engine state
  scde_pkg::scde_state_e st;
  logic [2:0]          act;             // channel being served
  logic [2:0]          last_lo;         // round robin pointers
  logic [2:0]          last_hi;
  logic                half;            // second word of a double word
  logic [15:0]         data;            // word between read and write
  // bus decode
  logic                wb_req;
  logic                wr_en;
  logic [2:0]          pg;
  logic [2:0]          rg;
  logic [15:0]         wd;
  logic [31:0]         rd_val;
  // arbitration
  logic [N-1:0]        ready;
  logic [N-1:0]        rdy_hi;
  logic [3:0]          pick_hi;
  logic [3:0]          pick_lo;
  logic [2:0]          rs;              // reload set of active channel
  logic                elast;           // last element of the frame
  logic                flast;           // last frame of the block
  logic                xlast;           // last 16-bit transfer of frame
  logic                count_now;       // element done this update

  // rotating search from the one after last served
  function automatic logic [3:0] pick(input logic [N-1:0] req,
                                      input logic [2:0]   last);
    logic [3:0] res;
    logic [2:0] j;
    res = 4'h0;
    j   = last;
    for (int i = 0; i < N; i++)
    begin
      j = (j == 3'(N - 1)) ? 3'h0 : 3'(j + 3'h1);
      if (!res[3] && req[j])
      begin
        res = {1'b1, j};
      end
    end
    return res;
  endfunction : pick

  // post-transfer address adjustment, shared by source and destination
  function automatic logic [15:0] adjust(input logic [15:0] a,
                                         input logic [1:0]  how,
                                         input logic        fr_end,
                                         input logic [15:0] es,
                                         input logic [15:0] fs);
    logic [15:0] r;
    case (how)
      scde_pkg::ADJ_INC: r = 16'(a + 16'h0001);
      scde_pkg::ADJ_DEC: r = 16'(a - 16'h0001);
      scde_pkg::ADJ_IDX: r = 16'(a + (fr_end ? fs : es));
      default:           r = a;
    endcase
    return r;
  endfunction : adjust

  // address decode of the bus request
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  // writes land at the edge where the master samples ack high
  assign wr_en  = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I &&
                  WB_SEL_I[0] && WB_SEL_I[1];
  assign pg     = WB_ADR_I[7:5];
  assign rg     = WB_ADR_I[4:2];
  assign wd     = WB_DAT_I[15:0];

  // channel ready: enabled and either free running or event seen
  always_comb
  begin
    for (int c = 0; c < N; c++)
    begin
      ready[c]  = enable[c] &&
                  (channel_mode_control[c].sync == 3'h0 || pend[c]);
      rdy_hi[c] = ready[c] && channel_mode_control[c].hipri;
    end
  end

  assign pick_hi = pick(rdy_hi, last_hi);
  assign pick_lo = pick(ready, last_lo);
  assign rs      = scde_pkg::PER_CH_RELOAD ? act : 3'h0;
  assign elast   = element_counter[act] == 16'h0000;
  assign flast   = frame_counter[act] == 8'h00;
  assign xlast   = elast && (!channel_mode_control[act].dword || half);
  assign count_now = !channel_mode_control[act].dword || half;

  // bus answer: one wait state, ack for one cycle, unmapped reads zero
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_val : 32'h00000000;
    end
  end

  // read multiplexer
  always_comb
  begin
    rd_val = 32'h00000000;
    if (pg < 3'(N))
    begin
      case (rg)
        scde_pkg::REG_SRC:   rd_val[15:0] = source_pointer[pg];
        scde_pkg::REG_DST:   rd_val[15:0] = destination_pointer[pg];
        scde_pkg::REG_ECNT:  rd_val[15:0] = element_counter[pg];
        scde_pkg::REG_FCNT:  rd_val[7:0]  = frame_counter[pg];
        scde_pkg::REG_MODE:  rd_val[15:0] = channel_mode_control[pg];
        scde_pkg::REG_ESIZE: rd_val[15:0] = element_size[pg];
        default:             rd_val = 32'h00000000;
      endcase
    end
    else if (pg == scde_pkg::PAGE_GLOBAL)
    begin
      case (rg)
        scde_pkg::G_SRC:   rd_val[15:0] = global_source_reload[rsel];
        scde_pkg::G_DST:   rd_val[15:0] =
                             global_destination_reload[rsel];
        scde_pkg::G_CNT:   rd_val[15:0] = global_count_reload[rsel];
        scde_pkg::G_FRM:   rd_val[7:0]  = global_frame_reload[rsel];
        scde_pkg::G_ESTEP: rd_val[15:0] = element_step_0;
        scde_pkg::G_FSTEP: rd_val[15:0] = frame_step_0;
        default:           rd_val = 32'h00000000;
      endcase
    end
    else
    begin
      case (rg)
        scde_pkg::C_ENABLE: rd_val[N-1:0] = enable;
        scde_pkg::C_RSEL:   rd_val[2:0]   = rsel;
        scde_pkg::C_STATUS: rd_val[15:0]  =
          {4'h0, 1'(st != scde_pkg::ST_IDLE), act, 2'h0, pend};
        default:            rd_val = 32'h00000000;
      endcase
    end
  end

  // reload registers and steps: written only by software, kept forever
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int c = 0; c < N; c++)
      begin
        global_source_reload[c]      <= scde_pkg::WORD_RST;
        global_destination_reload[c] <= scde_pkg::WORD_RST;
        global_count_reload[c]       <= scde_pkg::WORD_RST;
        global_frame_reload[c]       <= scde_pkg::FRAME_RST;
      end
      element_step_0 <= scde_pkg::WORD_RST;
      frame_step_0   <= scde_pkg::WORD_RST;
      rsel           <= 3'h0;
    end
    else if (wr_en && pg == scde_pkg::PAGE_GLOBAL)
    begin
      case (rg)
        scde_pkg::G_SRC:   global_source_reload[rsel]      <= wd;
        scde_pkg::G_DST:   global_destination_reload[rsel] <= wd;
        scde_pkg::G_CNT:   global_count_reload[rsel]       <= wd;
        scde_pkg::G_FRM:   global_frame_reload[rsel]       <= wd[7:0];
        scde_pkg::G_ESTEP: element_step_0                  <= wd;
        scde_pkg::G_FSTEP: frame_step_0                    <= wd;
        default:           ;
      endcase
    end
    else if (wr_en && pg == scde_pkg::PAGE_CTRL && rg == scde_pkg::C_RSEL)
    begin
      // reload set pointer, only meaningful in the per-channel variant
      rsel <= (scde_pkg::PER_CH_RELOAD && wd[2:0] < 3'(N)) ?
              wd[2:0] : 3'h0;
    end
  end

  // transfer sequencer: five cycles per 16-bit move
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      st      <= scde_pkg::ST_IDLE;
      act     <= 3'h0;
      last_lo <= 3'(N - 1);
      last_hi <= 3'(N - 1);
      half    <= 1'b0;
    end
    else
    begin
      case (st)
        scde_pkg::ST_IDLE:
        begin
          // high level first, then round robin within level
          if (pick_hi[3])
          begin
            act     <= pick_hi[2:0];
            last_hi <= pick_hi[2:0];
            st      <= scde_pkg::ST_RD;
          end
          else if (pick_lo[3])
          begin
            act     <= pick_lo[2:0];
            last_lo <= pick_lo[2:0];
            st      <= scde_pkg::ST_RD;
          end
          half <= 1'b0;
        end
        scde_pkg::ST_RD:   st <= scde_pkg::ST_WAIT;
        scde_pkg::ST_WAIT: st <= scde_pkg::ST_CAP;
        scde_pkg::ST_CAP:  st <= scde_pkg::ST_WR;
        scde_pkg::ST_WR:   st <= scde_pkg::ST_UPD;
        scde_pkg::ST_UPD:
        begin
          // second half of a double word follows without arbitration
          if (channel_mode_control[act].dword && !half)
          begin
            half <= 1'b1;
            st   <= scde_pkg::ST_RD;
          end
          else
          begin
            half <= 1'b0;
            st   <= scde_pkg::ST_IDLE;
          end
        end
        default: st <= scde_pkg::ST_IDLE;
      endcase
    end
  end

  // data latch between read and write
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      data <= scde_pkg::WORD_RST;
    end
    else if (st == scde_pkg::ST_CAP)
    begin
      data <= MEM_RDAT;
    end
  end

  // memory request outputs; decode uses address only
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      MEM_O <= '0;
    end
    else
    begin
      MEM_O.rd <= st == scde_pkg::ST_IDLE && (pick_hi[3] || pick_lo[3]) ||
                  st == scde_pkg::ST_UPD &&
                  channel_mode_control[act].dword && !half;
      MEM_O.wr <= st == scde_pkg::ST_CAP;
      if (st == scde_pkg::ST_CAP)
      begin
        MEM_O.addr <= destination_pointer[act];
        MEM_O.ext  <= destination_pointer[act] >= scde_pkg::ONCHIP_TOP;
        MEM_O.wdat <= MEM_RDAT;
      end
      else if (st == scde_pkg::ST_IDLE || st == scde_pkg::ST_UPD)
      begin
        MEM_O.addr <= pick_hi[3] || st == scde_pkg::ST_UPD ?
                      source_pointer[st == scde_pkg::ST_UPD ?
                                     act : pick_hi[2:0]] :
                      source_pointer[pick_lo[2:0]];
        MEM_O.ext  <= 1'b0;
      end
    end
  end

  // CPU gets memory only when the engine neither runs nor wants to
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      CPU_GNT <= 1'b0;
    end
    else
    begin
      CPU_GNT <= CPU_REQ && st == scde_pkg::ST_IDLE && ready == '0;
    end
  end

  // interrupt pulses at frame and block end
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      IRQ <= '0;
    end
    else
    begin
      IRQ <= '0;
      if (st == scde_pkg::ST_UPD && count_now && elast &&
          channel_mode_control[act].interrupt_enable_bit &&
          (flast || channel_mode_control[act].interrupt_mode_bit))
      begin
        IRQ[act] <= 1'b1;
      end
    end
  end

  // pending events: a new event beats the clear at grant
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      pend <= '0;
    end
    else
    begin
      for (int c = 0; c < N; c++)
      begin
        if (channel_mode_control[c].sync != 3'h0 &&
            EVENT[channel_mode_control[c].sync - 3'h1])
        begin
          pend[c] <= 1'b1;
        end
        else if (st == scde_pkg::ST_IDLE && ready[c] &&
                 (pick_hi[3] ? pick_hi[2:0] : pick_lo[2:0]) == 3'(c))
        begin
          pend[c] <= 1'b0;
        end
      end
    end
  end

  // channel contexts: engine updates, then software writes win
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int c = 0; c < N; c++)
      begin
        source_pointer[c]       <= scde_pkg::WORD_RST;
        destination_pointer[c]  <= scde_pkg::WORD_RST;
        element_counter[c]      <= scde_pkg::WORD_RST;
        element_size[c]         <= scde_pkg::WORD_RST;
        frame_counter[c]        <= scde_pkg::FRAME_RST;
        channel_mode_control[c] <= scde_pkg::MODE_RST;
      end
      enable <= '0;
    end
    else
    begin
      // source moves after each read
      if (st == scde_pkg::ST_CAP)
      begin
        source_pointer[act] <= adjust(source_pointer[act],
          channel_mode_control[act].src_adj, xlast,
          element_step_0, frame_step_0);
      end
      // destination moves after each write, counters after element
      if (st == scde_pkg::ST_UPD)
      begin
        destination_pointer[act] <= adjust(destination_pointer[act],
          channel_mode_control[act].dst_adj, xlast,
          element_step_0, frame_step_0);
        if (count_now && !elast)
        begin
          element_counter[act] <= 16'(element_counter[act] - 16'h1);
        end
        else if (count_now && !flast)
        begin
          frame_counter[act]   <= 8'(frame_counter[act] - 8'h01);
          element_counter[act] <= element_size[act];
        end
        else if (count_now && channel_mode_control[act].auto_reload_flag)
        begin
          source_pointer[act]      <= global_source_reload[rs];
          destination_pointer[act] <= global_destination_reload[rs];
          element_counter[act]     <= global_count_reload[rs];
          element_size[act]        <= global_count_reload[rs];
          frame_counter[act]       <= global_frame_reload[rs];
        end
        else if (count_now)
        begin
          enable[act] <= 1'b0;
        end
      end
      // software writes
      if (wr_en && pg < 3'(N))
      begin
        case (rg)
          scde_pkg::REG_SRC:   source_pointer[pg]      <= wd;
          scde_pkg::REG_DST:   destination_pointer[pg] <= wd;
          scde_pkg::REG_ECNT:
          begin
            element_counter[pg] <= wd;
            element_size[pg]    <= wd;
          end
          scde_pkg::REG_FCNT:  frame_counter[pg]       <= wd[7:0];
          scde_pkg::REG_MODE:  channel_mode_control[pg] <= wd;
          scde_pkg::REG_ESIZE: element_size[pg]        <= wd;
          default:             ;
        endcase
      end
      else if (wr_en && pg == scde_pkg::PAGE_CTRL &&
               rg == scde_pkg::C_ENABLE)
      begin
        enable <= wd[N-1:0];
      end
    end
  end

endmodule : scde_engine

// [test/scde_engine_checker.sv]
`timescale 1ns/1ps

// watches bus answers, memory port timing, grant and interrupts
module scde_engine_checker (
  input wire logic                CLK,
  input wire logic                ARST_N,
  input wire logic                WB_CYC_I,
  input wire logic                WB_STB_I,
  input wire logic [31:0]         WB_DAT_O,
  input wire logic                WB_ACK_O,
  input wire scde_pkg::scde_mem_s MEM_O,
  input wire logic                CPU_REQ,
  input wire logic                CPU_GNT,
  input wire logic [5:0]          IRQ
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!ARST_N);

  // a new request is answered one cycle later
  property p_ack_lat;
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  // ack is a single cycle pulse
  property p_ack_pulse;
    WB_ACK_O |=> !WB_ACK_O;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
  // read data is zero outside ack
  property p_dat_idle;
    !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("dat idle");
  // write phase comes three cycles after the read phase
  property p_rd_wr;
    MEM_O.rd |=> !MEM_O.wr [*2] ##1 MEM_O.wr;
  endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("rd to wr");
  // read strobe lasts one cycle
  property p_rd_pulse;
    MEM_O.rd |=> !MEM_O.rd;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("rd long");
  // at least four cycles without a write between writes
  property p_wr_gap;
    MEM_O.wr |=> !MEM_O.wr [*4];
  endproperty
  a_wr_gap: assert property (p_wr_gap) else $error("wr gap");
  // external flag follows the fixed on-chip boundary
  property p_ext;
    MEM_O.wr |-> MEM_O.ext == (MEM_O.addr >= 16'h8000);
  endproperty
  a_ext: assert property (p_ext) else $error("ext decode");
  // no cpu grant while the engine uses memory
  property p_no_gnt;
    MEM_O.rd || MEM_O.wr |-> !CPU_GNT;
  endproperty
  a_no_gnt: assert property (p_no_gnt) else $error("gnt busy");
  // grant only follows a request
  property p_gnt_req;
    CPU_GNT |-> $past(CPU_REQ);
  endproperty
  a_gnt_req: assert property (p_gnt_req) else $error("gnt stray");
  // interrupts follow a write phase closely
  property p_irq;
    IRQ != 6'h00 |-> $past(MEM_O.wr) || $past(MEM_O.wr, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("irq stray");
  c_ext: cover property (MEM_O.wr && MEM_O.ext);
  c_irq: cover property (IRQ != 6'h00);
  c_gnt: cover property (CPU_GNT);
endmodule : scde_engine_checker

// [test/scde_mem_model.sv]
`timescale 1ns/1ps

// memory beside the engine: two cycle read data, never stalls
module scde_mem_model (
  input wire logic                CLK,
  input wire scde_pkg::scde_mem_s MEM_O,
  output logic [15:0]             MEM_RDAT
);
  logic [15:0] mem [0:65535]; // word store
  logic        rd_q;          // read strobe seen last cycle
  logic [15:0] addr_q;        // its address

  // known pattern in every word
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 16'(i) ^ 16'h5A5A;
    MEM_RDAT = 16'h0000;
    rd_q     = 1'b0;
    addr_q   = 16'h0000;
  end

  // data valid two cycles after rd, scrambled otherwise
  always @(posedge CLK)
  begin
    rd_q   <= MEM_O.rd;
    addr_q <= MEM_O.addr;
    if (rd_q)
      MEM_RDAT <= mem[addr_q];
    else
      MEM_RDAT <= ~MEM_RDAT;
    if (MEM_O.wr)
      mem[MEM_O.addr] <= MEM_O.wdat;
  end
endmodule : scde_mem_model

// [test/tb.sv]
`timescale 1ns/1ps

module tb;
  logic                clk, arst_n, cyc, stb, we, ack, cpu_req, gnt;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         dat, dato, rd_v;
  logic [6:0]          ev;
  logic [15:0]         rdat;
  logic [5:0]          irq;
  scde_pkg::scde_mem_s mem_o;
  int                  errors, checks;
  int                  irq_n [6];

  scde_engine u_scde_engine (.CLK(clk), .ARST_N(arst_n), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack), .EVENT(ev),
    .MEM_RDAT(rdat), .MEM_O(mem_o), .CPU_REQ(cpu_req), .CPU_GNT(gnt),
    .IRQ(irq));
  scde_mem_model u_scde_mem_model (.CLK(clk), .MEM_O(mem_o),
    .MEM_RDAT(rdat));

  // 10 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // count interrupt pulses per channel
  always @(posedge clk)
    for (int i = 0; i < 6; i++)
      if (irq[i] === 1'b1)
        irq_n[i]++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one classic bus cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel} <= {2'b11, w, a, s};
    dat <= {16'h0000, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd_v = dato;
    {cyc, stb, we} <= 3'b000;
    if (n >= 20)
      errors++;
  endtask : wb

  function automatic logic [7:0] ra(input logic [2:0] p, input logic [2:0] r);
    return {p, r, 2'b00};
  endfunction : ra

  // compare a memory word with the pattern of its source
  task automatic cmp_mem(input logic [15:0] a, input logic [15:0] s);
    chk({16'h0000, u_scde_mem_model.mem[a]}, {16'h0000, s ^ 16'h5A5A});
  endtask : cmp_mem

  // program one channel, then enable only that channel
  task automatic chan(input logic [2:0] c, input logic [15:0] s, d, n, m);
    wb(1'b1, ra(c, scde_pkg::REG_SRC), s, 4'hF);
    wb(1'b1, ra(c, scde_pkg::REG_DST), d, 4'hF);
    wb(1'b1, ra(c, scde_pkg::REG_ECNT), n, 4'hF);
    wb(1'b1, ra(c, scde_pkg::REG_MODE), m, 4'hF);
    wb(1'b1, ra(3'h7, scde_pkg::C_ENABLE), 16'h0001 << c, 4'hF);
  endtask : chan

  // poll the enable bit until hardware clears it
  task automatic wait_done(input int c);
    for (int i = 0; i < 60; i++)
    begin
      wb(1'b0, ra(3'h7, scde_pkg::C_ENABLE), 16'h0000, 4'hF);
      if (rd_v[c] === 1'b0)
        break;
    end
    chk({31'h0, rd_v[c]}, 32'h0);
  endtask : wait_done

  task automatic test_done;
    $display("counts errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // hang guard
  initial
  begin
    #(100 * 20000);
    errors++;
    test_done;
  end

  initial
  begin
    {cyc, stb, we, cpu_req, arst_n} = 5'b00000;
    {adr, sel, dat, ev} = '0;
    {errors, checks} = '0;
    irq_n = '{default: 0};
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, unmapped place, partial select
    wb(1'b0, ra(3'h0, scde_pkg::REG_MODE), 16'h0000, 4'hF);
    chk(rd_v, 32'h0);
    wb(1'b0, ra(3'h0, scde_pkg::REG_FCNT), 16'h0000, 4'hF);
    chk(rd_v, 32'h0);
    wb(1'b0, 8'hEC, 16'h0000, 4'hF);
    chk(rd_v, 32'h0);
    wb(1'b1, ra(3'h0, scde_pkg::REG_SRC), 16'h1234, 4'hC);
    wb(1'b0, ra(3'h0, scde_pkg::REG_SRC), 16'h0000, 4'hF);
    chk(rd_v, 32'h0);
    $display("test registers done");
    // four element block, both pointers incrementing
    chan(3'h0, 16'h0010, 16'h8100, 16'h0003, 16'h0520);
    wait_done(0);
    for (int k = 0; k < 4; k++)
      cmp_mem(16'h8100 + 16'(k), 16'h0010 + 16'(k));
    cmp_mem(16'h8104, 16'h8104);
    wb(1'b0, ra(3'h0, scde_pkg::REG_SRC), 16'h0000, 4'hF);
    chk(rd_v, 32'h0014);
    wb(1'b0, ra(3'h0, scde_pkg::REG_DST), 16'h0000, 4'hF);
    chk(rd_v, 32'h8104);
    chk(irq_n[0], 1);
    $display("test block done");
    // double word, source decrementing
    chan(3'h1, 16'h0031, 16'h8200, 16'h0000, 16'h06A0);
    wait_done(1);
    cmp_mem(16'h8200, 16'h0031);
    cmp_mem(16'h8201, 16'h0030);
    cmp_mem(16'h8202, 16'h8202);
    $display("test double word done");
    // auto reload from the shared reload set
    wb(1'b1, ra(3'h6, scde_pkg::G_SRC), 16'h0060, 4'hF);
    wb(1'b1, ra(3'h6, scde_pkg::G_DST), 16'h8300, 4'hF);
    wb(1'b1, ra(3'h6, scde_pkg::G_CNT), 16'h0001, 4'hF);
    wb(1'b1, ra(3'h6, scde_pkg::G_FRM), 16'h0000, 4'hF);
    chan(3'h2, 16'h0050, 16'h8300, 16'h0001, 16'h0530);
    for (int i = 0; i < 400 && irq_n[2] < 2; i++)
      @(posedge clk);
    wb(1'b1, ra(3'h7, scde_pkg::C_ENABLE), 16'h0000, 4'hF);
    repeat (20) @(posedge clk);
    cmp_mem(16'h8300, 16'h0060);
    cmp_mem(16'h8301, 16'h0061);
    cmp_mem(16'h8302, 16'h8302);
    chk(32'(irq_n[2] >= 2), 32'h1);
    $display("test reload done");
    // transfer waits for its event
    chan(3'h3, 16'h0070, 16'h8400, 16'h0000, 16'h0501);
    repeat (30) @(posedge clk);
    cmp_mem(16'h8400, 16'h8400);
    ev <= 7'h01;
    @(posedge clk);
    ev <= 7'h00;
    wait_done(3);
    cmp_mem(16'h8400, 16'h0070);
    $display("test event done");
    // high priority channel served first, low one writes last
    wb(1'b1, ra(3'h4, scde_pkg::REG_SRC), 16'h0080, 4'hF);
    wb(1'b1, ra(3'h4, scde_pkg::REG_DST), 16'h8600, 4'hF);
    wb(1'b1, ra(3'h4, scde_pkg::REG_MODE), 16'h0520, 4'hF);
    wb(1'b1, ra(3'h5, scde_pkg::REG_SRC), 16'h0090, 4'hF);
    wb(1'b1, ra(3'h5, scde_pkg::REG_DST), 16'h8600, 4'hF);
    wb(1'b1, ra(3'h5, scde_pkg::REG_MODE), 16'h0528, 4'hF);
    wb(1'b1, ra(3'h7, scde_pkg::C_ENABLE), 16'h0030, 4'hF);
    wait_done(4);
    wait_done(5);
    cmp_mem(16'h8600, 16'h0080);
    $display("test priority done");
    // two frames of two, destination stepped by element and frame step
    wb(1'b1, ra(3'h6, scde_pkg::G_ESTEP), 16'h0002, 4'hF);
    wb(1'b1, ra(3'h6, scde_pkg::G_FSTEP), 16'h0010, 4'hF);
    wb(1'b1, ra(3'h0, scde_pkg::REG_FCNT), 16'h0001, 4'hF);
    chan(3'h0, 16'h00A0, 16'h8700, 16'h0001, 16'h0D60);
    wait_done(0);
    cmp_mem(16'h8700, 16'h00A0);
    cmp_mem(16'h8702, 16'h00A1);
    cmp_mem(16'h8712, 16'h00A2);
    cmp_mem(16'h8714, 16'h00A3);
    cmp_mem(16'h8701, 16'h8701);
    chk(irq_n[0], 3);
    $display("test frames done");
    // cpu granted when idle, engine still moves data
    cpu_req <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, gnt}, 32'h1);
    chan(3'h0, 16'h0020, 16'h8500, 16'h0000, 16'h0520);
    wait_done(0);
    cmp_mem(16'h8500, 16'h0020);
    $display("test cpu done");
    test_done;
  end
endmodule : tb

bind scde_engine scde_engine_checker u_scde_engine_checker (.CLK(CLK),
  .ARST_N(ARST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .MEM_O(MEM_O),
  .CPU_REQ(CPU_REQ), .CPU_GNT(CPU_GNT), .IRQ(IRQ));
